// >>> pkg/mcmd_pkg.sv
// Purpose: constants for the mode, option and address-decode block
// Assumes: 14-bit CPU address space, byte-wide data
// Notes: area codes are shared with the decoder select outputs
`default_nettype none
package mcmd_pkg;
    // address width of the 16-Kbyte map
    localparam int ADDR_W = 14;
    // software option register and the two mask option locations
    localparam logic [13:0] OPT_REG_ADDR = 14'h3FDF;
    localparam logic [13:0] PB_MOPT_ADDR = 14'h3FF0;
    localparam logic [13:0] MODE_MOPT_ADDR = 14'h3FF1;
    // map boundaries
    localparam logic [13:0] IO_LAST = 14'h001F;
    localparam logic [13:0] LOW_WIN_FIRST = 14'h0020;
    localparam logic [13:0] LOW_WIN_LAST = 14'h004F;
    localparam logic [13:0] RAM_FIRST = 14'h0050;
    localparam logic [13:0] RAM_LAST = 14'h00FF;
    localparam logic [13:0] STACK_FIRST = 14'h00C0;
    localparam logic [13:0] HIGH_WIN_FIRST = 14'h0100;
    localparam logic [13:0] HIGH_WIN_LAST = 14'h017F;
    localparam logic [13:0] EXT_EPROM_LAST = 14'h0FFF;
    localparam logic [13:0] MAIN_EPROM_FIRST = 14'h1000;
    localparam logic [13:0] MAIN_EPROM_LAST = 14'h3EFF;
    localparam logic [13:0] BOOT_FIRST = 14'h3F00;
    localparam logic [13:0] BOOT_LAST = 14'h3FEF;
    localparam logic [13:0] VECT_FIRST = 14'h3FF4;
    localparam logic [13:0] VECT_LAST = 14'h3FFF;
    // i/o block locations that depend on the mode
    localparam logic [13:0] PORTD_DIR_ADDR = 14'h0007;
    localparam logic [13:0] WDOG_RESET_ADDR = 14'h001D;
    localparam logic [13:0] WDOG_CTRL_ADDR = 14'h001E;
    // software option register fields
    localparam int OPT_LOW_BIT = 0;
    localparam int OPT_HIGH_BIT = 1;
    localparam int OPT_IRQ_BIT = 2;
    // mode mask option location fields
    localparam int MODE_COMPAT_BIT = 0;
    localparam int MODE_WDOG_BIT = 1;
    localparam int MODE_STOP_BIT = 2;
    localparam int MODE_IRQ_BIT = 3;
    localparam int MODE_PROT_BIT = 4;
    // reset values
    localparam logic [7:0] OPT_RESET = 8'h04;
    localparam logic [7:0] PORTD_DIR_RESET = 8'h00;
    // internal clock is one half of the crystal
    localparam int CLK_DIV = 2;
    // decoded areas
    typedef enum logic [3:0] {
        MCMD_AREA_NONE, MCMD_AREA_IO, MCMD_AREA_RAM, MCMD_AREA_EPROM,
        MCMD_AREA_BOOT, MCMD_AREA_OPT, MCMD_AREA_MOPT, MCMD_AREA_VECT
    } mcmd_area_type;
endpackage : mcmd_pkg
`default_nettype wire

// >>> src/mcmd_top.sv
// Purpose: option bits, mode control and 16-Kbyte address decode
// Assumes: cpu core drives addr, rd, wr and wdata synchronously
// Notes: mask options arrive from the eprom array as plain inputs
//
// How it works
// R1: watchdog option read-only, zero in full mode
// R2: protect bit blocks external eprom access
// R3: power-on reset always starts in full mode
// R4: option register works only in full mode
// R5: low overlay bit picks ram or eprom
// R6: high overlay bit picks ram or eprom
// R7: irq sensitivity set by reset, one write
// R8: compat mode fixes low eprom, no high map
// R9: main ram 0050-00FF always, stack at top
// R10: eprom areas per mode
// R11: mask options at 3FF0 and 3FF1
// R12: protect cleared only by full erase
// R13: bootloader rom at 3F00-3FEF
// R14: i/o registers within page-zero block
// R15: port d dir full mode; watchdog 001D/001E
// R16: port d input at reset, forced in compat
// R17: ports a, b, c inputs during reset
// R18: reset pin driven only in full mode
// R19: internal clock is half the crystal
// R20: compat select bit: 1 compat, 0 full
// R21: overlay change applies to next access
`default_nettype none
module mcmd_top
    import mcmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic crystal_input,
    // cpu access
    input wire logic [13:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic ext_access,
    output logic [7:0] rdata,
    // programmed mask options and erase event
    input wire logic [7:0] port_b_mopt,
    input wire logic [7:0] mode_mopt,
    input wire logic eprom_erased,
    input wire logic internal_reset,
    // decoded selects
    output logic [3:0] area_sel,
    output logic overlay_ram,
    output logic ext_blocked,
    // configuration out
    output logic compat_mode,
    output logic watchdog_enable_option,
    output logic irq_edge_level,
    output logic [7:0] port_d_dir,
    output logic port_abc_force_in,
    output logic reset_pin_low_n,
    output logic reset_pin_oe_n,
    output logic sys_clk_en
);
    // mode, option and decode state
    logic compat_q, next_compat;
    logic low_sel, next_low_sel;
    logic high_sel, next_high_sel;
    logic irq_sel, next_irq_sel;
    logic irq_written, next_irq_written;
    logic prot, next_prot;
    logic [7:0] pdir, next_pdir;
    logic [7:0] next_rdata;
    logic [3:0] next_area;
    logic next_ovl;
    logic div_q, next_div;
    logic rst_seen, next_rst_seen;
    logic opt_wr;
    logic pdir_wr;

    // software option register reachable only in full mode
    // R4: full mode gate
    assign opt_wr = wr && (addr == OPT_REG_ADDR) && !compat_q;
    // R15: port d direction exists in full mode only
    assign pdir_wr = wr && (addr == PORTD_DIR_ADDR) && !compat_q;

    // next-state for mode and option bits
    always_comb begin
        // R3: mode register starts in full mode; R20 picks compat later
        next_compat = compat_q;
        if (!rst_seen) begin
            // sample the strap once, one cycle after reset release
            next_compat = mode_mopt[MODE_COMPAT_BIT];
        end
        next_rst_seen = 1'b1;
        next_low_sel = low_sel;
        next_high_sel = high_sel;
        next_irq_sel = irq_sel;
        next_irq_written = irq_written;
        next_pdir = pdir;
        if (opt_wr) begin
            // R5: low overlay written by every option write, full mode only
            next_low_sel = wdata[OPT_LOW_BIT];
            // R6: high overlay written by every option write, full mode only
            next_high_sel = wdata[OPT_HIGH_BIT];
            // R7: only the first write can clear it
            if (!irq_written) begin
                next_irq_sel = wdata[OPT_IRQ_BIT];
                next_irq_written = 1'b1;
            end
        end
        // R16: software direction in full mode, forced input otherwise
        if (next_compat) begin
            next_pdir = PORTD_DIR_RESET;
        end else if (pdir_wr) begin
            next_pdir = wdata;
        end
        // R12: protect drops only with a full erase
        next_prot = prot | mode_mopt[MODE_PROT_BIT];
        if (eprom_erased) begin
            next_prot = 1'b0;
        end
        // R19: divide-by-two toggles each crystal-rate edge
        next_div = ~div_q;
    end

    // option and mode registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compat_q <= 1'b0;
            rst_seen <= 1'b0;
            low_sel <= OPT_RESET[OPT_LOW_BIT];
            high_sel <= OPT_RESET[OPT_HIGH_BIT];
            irq_sel <= OPT_RESET[OPT_IRQ_BIT];
            irq_written <= 1'b0;
            prot <= 1'b0;
            pdir <= PORTD_DIR_RESET;
            div_q <= 1'b0;
        end else begin
            compat_q <= next_compat;
            rst_seen <= next_rst_seen;
            low_sel <= next_low_sel;
            high_sel <= next_high_sel;
            irq_sel <= next_irq_sel;
            irq_written <= next_irq_written;
            prot <= next_prot;
            pdir <= next_pdir;
            div_q <= next_div;
        end
    end

    // address decode; uses live overlay bits so a change lands next access
    always_comb begin
        next_area = MCMD_AREA_NONE;
        next_ovl = 1'b0;
        // R14: i/o block in page zero
        if (addr <= IO_LAST) begin
            next_area = MCMD_AREA_IO;
            // R15: watchdog locations vanish in compat mode
            if (compat_q && ((addr == PORTD_DIR_ADDR) || (addr == WDOG_RESET_ADDR) ||
                    (addr == WDOG_CTRL_ADDR))) begin
                next_area = MCMD_AREA_NONE;
            end
        end else if (addr <= LOW_WIN_LAST) begin
            // R5, R8, R21: low window ram only in full mode with bit set
            next_ovl = !compat_q && next_low_sel;
            next_area = next_ovl ? MCMD_AREA_RAM : MCMD_AREA_EPROM;
        end else if (addr <= RAM_LAST) begin
            // R9: main ram in both modes
            next_area = MCMD_AREA_RAM;
        end else if (addr <= EXT_EPROM_LAST) begin
            // R8, R10: 0100-0FFF exists in full mode only
            if (!compat_q) begin
                // R6, R21: high window
                next_ovl = next_high_sel && (addr <= HIGH_WIN_LAST);
                next_area = next_ovl ? MCMD_AREA_RAM : MCMD_AREA_EPROM;
            end
        end else if (addr <= MAIN_EPROM_LAST) begin
            // R10: main eprom
            next_area = MCMD_AREA_EPROM;
        end else if (addr == OPT_REG_ADDR) begin
            // option register sits inside the boot range, so it is tested first
            next_area = MCMD_AREA_OPT;
        end else if (addr >= BOOT_FIRST && addr <= BOOT_LAST) begin
            // R13: bootloader rom, the boot range minus the option register
            next_area = MCMD_AREA_BOOT;
        end else if (addr == PB_MOPT_ADDR || addr == MODE_MOPT_ADDR) begin
            // R11: mask option locations
            next_area = MCMD_AREA_MOPT;
        end else if (addr >= VECT_FIRST) begin
            // R10: user vectors
            next_area = MCMD_AREA_VECT;
        end
    end

    // read data for the locations this block owns
    always_comb begin
        next_rdata = 8'h00;
        if (rd) begin
            if (addr == OPT_REG_ADDR && !compat_q) begin
                next_rdata[OPT_LOW_BIT] = low_sel;
                next_rdata[OPT_HIGH_BIT] = high_sel;
                next_rdata[OPT_IRQ_BIT] = irq_sel;
            end else if (addr == PORTD_DIR_ADDR && !compat_q) begin
                next_rdata = pdir;
            end else if (addr == PB_MOPT_ADDR) begin
                next_rdata = port_b_mopt;
            end else if (addr == MODE_MOPT_ADDR) begin
                next_rdata = mode_mopt;
                // R1: watchdog and compat-only bits read zero in full mode
                if (!compat_q) begin
                    next_rdata[MODE_WDOG_BIT] = 1'b0;
                    next_rdata[MODE_STOP_BIT] = 1'b0;
                    next_rdata[MODE_IRQ_BIT] = 1'b0;
                end
            end
        end
    end

    // registered outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
            area_sel <= 4'h0;
            overlay_ram <= 1'b0;
            ext_blocked <= 1'b0;
            compat_mode <= 1'b0;
            watchdog_enable_option <= 1'b0;
            irq_edge_level <= 1'b1;
            port_d_dir <= 8'h00;
            // R17: ports a, b, c held as inputs in reset
            port_abc_force_in <= 1'b1;
            reset_pin_low_n <= 1'b0;
            reset_pin_oe_n <= 1'b1;
            sys_clk_en <= 1'b0;
        end else begin
            rdata <= next_rdata;
            area_sel <= next_area;
            overlay_ram <= next_ovl;
            // R2: external eprom access refused while protected
            ext_blocked <= ext_access && next_prot;
            compat_mode <= next_compat;
            // R1: watchdog option effective in compat mode only
            watchdog_enable_option <= next_compat && mode_mopt[MODE_WDOG_BIT];
            // R7: compat mode takes the mask option bit instead
            irq_edge_level <= next_compat ? mode_mopt[MODE_IRQ_BIT] : next_irq_sel;
            port_d_dir <= next_pdir;
            port_abc_force_in <= 1'b0;
            // R18: drive reset pin low on internal reset in full mode
            reset_pin_low_n <= 1'b0;
            reset_pin_oe_n <= !(internal_reset && !next_compat);
            // R19: internal clock enable at half rate
            sys_clk_en <= next_div;
        end
    end

    // reads inside either overlay window, with no write in the same cycle
    sequence s_low_window;
        !wr && (addr >= LOW_WIN_FIRST) && (addr <= LOW_WIN_LAST);
    endsequence
    sequence s_high_window;
        !wr && (addr >= HIGH_WIN_FIRST) && (addr <= HIGH_WIN_LAST);
    endsequence

    // irq sensitivity never returns to one after the one write
    a_irq_once: assert property (@(posedge clk) disable iff (rst) // R7
        (irq_written && !irq_sel) |=> !irq_sel)
        else $error("irq sensitivity changed after its one write");
    // full mode right after reset release
    a_full_at_reset: assert property (@(posedge clk) disable iff (rst) // R3
        !rst_seen |-> !compat_q)
        else $error("compat mode before strap sampling");
    // watchdog option zero in full mode
    a_wdog_full: assert property (@(posedge clk) disable iff (rst) // R1
        !compat_mode |-> !watchdog_enable_option)
        else $error("watchdog option active in full mode");
    // no ram overlay in compat mode
    a_compat_noovl: assert property (@(posedge clk) disable iff (rst) // R8
        compat_mode |-> !overlay_ram)
        else $error("overlay ram in compat mode");
    // compat mode leaves 0100-0FFF unused
    a_compat_hole: assert property (@(posedge clk) disable iff (rst) // R8
        (compat_q && (addr >= HIGH_WIN_FIRST) && (addr <= EXT_EPROM_LAST))
        |=> area_sel == MCMD_AREA_NONE)
        else $error("upper eprom decoded in compat mode");
    // main ram always decoded
    a_main_ram: assert property (@(posedge clk) disable iff (rst) // R9
        (addr >= RAM_FIRST && addr <= RAM_LAST) |=> area_sel == MCMD_AREA_RAM)
        else $error("main ram not decoded");
    // boot rom decode; the option register is carved out of it
    a_boot_rom: assert property (@(posedge clk) disable iff (rst) // R13
        (addr >= BOOT_FIRST && addr <= BOOT_LAST && addr != OPT_REG_ADDR)
        |=> area_sel == MCMD_AREA_BOOT)
        else $error("boot rom not decoded");
    // option register decodes ahead of the boot rom
    a_opt_loc: assert property (@(posedge clk) disable iff (rst) // R13
        (addr == OPT_REG_ADDR) |=> area_sel == MCMD_AREA_OPT)
        else $error("option register not decoded");
    // both mask option locations decode
    a_mopt_loc: assert property (@(posedge clk) disable iff (rst) // R11
        (addr == PB_MOPT_ADDR || addr == MODE_MOPT_ADDR) |=> area_sel == MCMD_AREA_MOPT)
        else $error("mask option location not decoded");
    // page-zero i/o block in full mode
    a_io_block: assert property (@(posedge clk) disable iff (rst) // R14
        (!compat_q && (addr <= IO_LAST)) |=> area_sel == MCMD_AREA_IO)
        else $error("i/o block not decoded");
    // watchdog locations absent in compat mode
    a_wdog_compat: assert property (@(posedge clk) disable iff (rst) // R15
        (compat_q && ((addr == WDOG_RESET_ADDR) || (addr == WDOG_CTRL_ADDR)))
        |=> area_sel == MCMD_AREA_NONE)
        else $error("watchdog location decoded in compat mode");
    // option register reads zero in compat mode
    a_opt_compat: assert property (@(posedge clk) disable iff (rst) // R4
        (compat_q && rd && (addr == OPT_REG_ADDR)) |=> rdata == 8'h00)
        else $error("option register visible in compat mode");
    // a low window read right after setting the bit lands in ram
    a_low_ram: assert property (@(posedge clk) disable iff (rst) // R21
        (opt_wr && wdata[OPT_LOW_BIT]) ##1 s_low_window |=> area_sel == MCMD_AREA_RAM)
        else $error("low window not ram after overlay set");
    // a low window read right after clearing the bit lands in eprom
    a_low_eprom: assert property (@(posedge clk) disable iff (rst) // R5
        (opt_wr && !wdata[OPT_LOW_BIT]) ##1 s_low_window |=> area_sel == MCMD_AREA_EPROM)
        else $error("low window not eprom after overlay clear");
    // a high window read right after setting the bit lands in ram
    a_high_ram: assert property (@(posedge clk) disable iff (rst) // R6
        (opt_wr && wdata[OPT_HIGH_BIT]) ##1 s_high_window |=> area_sel == MCMD_AREA_RAM)
        else $error("high window not ram after overlay set");
    // protected part refuses the external request
    a_prot_block: assert property (@(posedge clk) disable iff (rst) // R2
        (ext_access && prot && !eprom_erased) |=> ext_blocked)
        else $error("external access not blocked while protected");
    // once blocking, only an erase lifts it
    a_prot_sticky: assert property (@(posedge clk) disable iff (rst) // R12
        (ext_blocked && ext_access && !eprom_erased) |=> ext_blocked)
        else $error("protection lifted without erase");
    // port d stays input in compat mode
    a_pdir_compat: assert property (@(posedge clk) disable iff (rst) // R16
        compat_mode |-> port_d_dir == 8'h00)
        else $error("port d output in compat mode");
    // reset pin not driven in compat mode
    a_rstpin_compat: assert property (@(posedge clk) disable iff (rst) // R18
        compat_mode |-> reset_pin_oe_n)
        else $error("reset pin driven in compat mode");
    // internal reset drives the pin in full mode
    a_rstpin_full: assert property (@(posedge clk) disable iff (rst) // R18
        (internal_reset && rst_seen && !compat_q) |=> !reset_pin_oe_n)
        else $error("reset pin not driven in full mode");
    // clock enable alternates
    a_half_clk: assert property (@(posedge clk) disable iff (rst) // R19
        sys_clk_en |=> !sys_clk_en)
        else $error("internal clock not at half rate");
endmodule : mcmd_top
`default_nettype wire

// >>> verif/mcmd_cpu_model.sv
// Purpose: cpu core model issuing byte reads and writes
// Assumes: one access per cycle, taken at the next rising edge
// Notes: idle bus shows inverted values so stale data never matches
`default_nettype none
module mcmd_cpu_model (
    // clock
    input wire logic clk,
    // bus toward the block
    output logic [13:0] addr,
    output logic rd,
    output logic wr,
    output logic [7:0] wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // bus starts idle
    initial begin
        addr = 14'h0000;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 8'h00;
    end
    // launch one access; held until the next call, so calls may run back to back
    task automatic access(input logic [13:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= ~w;
        wr <= w;
        wdata <= d;
    endtask : access
    // release only after the launching access was taken
    task automatic idle();
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
        addr <= ~addr;
        wdata <= ~wdata;
    endtask : idle
endmodule : mcmd_cpu_model
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the mode and decode block
// Assumes: cpu model drives the bus, bench drives straps and events
// Notes: expected areas come from a small map model kept here
`default_nettype none
module tb_top import mcmd_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // stimulus and design outputs
    logic clk, rst, crystal_input, ext_access, eprom_erased, internal_reset, rd, wr, p, ov;
    logic [13:0] addr, a;
    logic [7:0] wdata, rdata, port_b_mopt, mode_mopt, d, port_d_dir;
    logic [3:0] area_sel;
    logic overlay_ram, ext_blocked, compat_mode, watchdog_enable_option, irq_edge_level;
    logic port_abc_force_in, reset_pin_low_n, reset_pin_oe_n, sys_clk_en;
    // model state of the option register
    logic lo, hi, irq;
    int seed, err_count, cmp_count, cycles;
    // fixed probe points for the compatibility map
    logic [13:0] tbl [13] = '{14'h0020, 14'h004F, 14'h0100, 14'h0FFF, 14'h0050, 14'h00C0,
        14'h3F00, 14'h3FEF, 14'h3FF0, 14'h3FF1, 14'h3FF4, 14'h1000, 14'h001D};
    mcmd_cpu_model cpu (.clk(clk), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata));
    mcmd_top mcmd_top_inst (.clk(clk), .rst(rst), .crystal_input(crystal_input),
        .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .ext_access(ext_access),
        .rdata(rdata), .port_b_mopt(port_b_mopt), .mode_mopt(mode_mopt),
        .eprom_erased(eprom_erased), .internal_reset(internal_reset), .area_sel(area_sel),
        .overlay_ram(overlay_ram), .ext_blocked(ext_blocked), .compat_mode(compat_mode),
        .watchdog_enable_option(watchdog_enable_option), .irq_edge_level(irq_edge_level),
        .port_d_dir(port_d_dir), .port_abc_force_in(port_abc_force_in),
        .reset_pin_low_n(reset_pin_low_n), .reset_pin_oe_n(reset_pin_oe_n),
        .sys_clk_en(sys_clk_en));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // expected area; F marks gaps the map leaves open, which are not checked
    function automatic logic [3:0] exp_area(logic [13:0] x, logic c, logic l, logic h);
        if (c && (x == 14'h0007 || x == 14'h001D || x == 14'h001E)) return MCMD_AREA_NONE;
        if (x <= 14'h001F) return MCMD_AREA_IO;
        if (x <= 14'h004F) return (l && !c) ? MCMD_AREA_RAM : MCMD_AREA_EPROM;
        if (x <= 14'h00FF) return MCMD_AREA_RAM;
        if (c && x <= 14'h0FFF) return MCMD_AREA_NONE;
        if (x <= 14'h017F) return h ? MCMD_AREA_RAM : MCMD_AREA_EPROM;
        if (x <= 14'h3EFF) return MCMD_AREA_EPROM;
        if (x == 14'h3FDF) return MCMD_AREA_OPT;
        if (x <= 14'h3FEF) return MCMD_AREA_BOOT;
        if (x <= 14'h3FF1) return MCMD_AREA_MOPT;
        if (x >= 14'h3FF4) return MCMD_AREA_VECT;
        return 4'hF;
    endfunction : exp_area
    // one comparison, counted
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // read one location and let the registered answer settle
    task automatic rd_area(input logic [13:0] x);
        cpu.access(x, 1'b0, 8'h00);
        cpu.idle();
        #1;
    endtask : rd_area
    // wait n edges after driving an event input
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    // reset with a given mode strap; checks levels during and after
    task automatic do_reset(input logic [7:0] m);
        @(posedge clk);
        rst <= 1'b1;
        mode_mopt <= m;
        settle(3);
        chk(compat_mode, 8'h00);
        chk({irq_edge_level, port_abc_force_in, reset_pin_oe_n}, 8'h07);
        chk(port_d_dir, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        settle(3);
        chk({compat_mode, port_abc_force_in}, {6'h00, m[0], 1'b0});
        chk(watchdog_enable_option, {7'h00, m[0] & m[1]});
        lo = 1'b0;
        hi = 1'b0;
        irq = 1'b1;
    endtask : do_reset
    // verdict, reached from the main sequence or the hang limit
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    // hang limit, far above the roughly 1600 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        seed = 72976;
        err_count = 0;
        cmp_count = 0;
        cycles = 0;
        rst = 1'b1;
        crystal_input = 1'b0;
        ext_access = 1'b0;
        eprom_erased = 1'b0;
        internal_reset = 1'b0;
        mode_mopt = 8'h1B;
        port_b_mopt = 8'($random(seed));
        // compatibility mode: option and direction writes must be refused
        do_reset(8'h1B);
        cpu.access(14'h3FDF, 1'b1, 8'h03);
        cpu.access(14'h0007, 1'b1, 8'hFF);
        cpu.idle();
        #1;
        chk(port_d_dir, 8'h00);
        foreach (tbl[i]) begin
            rd_area(tbl[i]);
            chk(area_sel, exp_area(tbl[i], 1'b1, 1'b0, 1'b0));
        end
        rd_area(14'h3FF0);
        chk(rdata, port_b_mopt);
        rd_area(14'h3FF1);
        chk(rdata, mode_mopt);
        rd_area(14'h3FDF);
        chk(rdata, 8'h00);
        // protection holds until an erase event
        @(posedge clk) ext_access <= 1'b1;
        settle(2);
        chk(ext_blocked, 8'h01);
        // the strap bit dropping alone must not lift it; an erase clears the strap too
        @(posedge clk) mode_mopt <= 8'h0B;
        settle(2);
        chk(ext_blocked, 8'h01);
        @(posedge clk) eprom_erased <= 1'b1;
        @(posedge clk) eprom_erased <= 1'b0;
        settle(2);
        chk(ext_blocked, 8'h00);
        // internal reset must not drive the pin here
        @(posedge clk) internal_reset <= 1'b1;
        settle(2);
        chk(reset_pin_oe_n, 8'h01);
        @(posedge clk) internal_reset <= 1'b0;
        // full mode
        do_reset(8'h1A);
        chk(ext_blocked, 8'h01);
        cpu.access(14'h0007, 1'b1, 8'hA5);
        cpu.idle();
        #1;
        chk(port_d_dir, 8'hA5);
        rd_area(14'h3FF1);
        chk(rdata, mode_mopt & 8'hF1);
        repeat (4) begin
            p = sys_clk_en;
            settle(1);
            chk(sys_clk_en, {7'h00, ~p});
        end
        // first write clears the irq bit; later writes carry random bit 2
        cpu.access(14'h3FDF, 1'b1, 8'h00);
        irq = 1'b0;
        repeat (300) begin
            d = 8'($random(seed));
            a = 14'($random(seed));
            // steer most reads into the two overlay windows
            if (d[7]) a = 14'h0020 + {8'h00, a[5:0]};
            else if (d[6]) a = {7'h02, a[6:0]};
            cpu.access(14'h3FDF, 1'b1, d);
            lo = d[0];
            hi = d[1];
            cpu.access(a, 1'b0, 8'h00);
            cpu.idle();
            #1;
            if (exp_area(a, 1'b0, lo, hi) !== 4'hF) begin
                chk(area_sel, exp_area(a, 1'b0, lo, hi));
            end
            ov = lo && a >= 14'h0020 && a <= 14'h004F;
            ov = ov || (hi && a >= 14'h0100 && a <= 14'h017F);
            chk(overlay_ram, {7'h00, ov});
            rd_area(14'h3FDF);
            chk(rdata & 8'h07, {5'h00, irq, hi, lo});
            chk(irq_edge_level, {7'h00, irq});
        end
        // internal reset drives the pin low in this mode
        @(posedge clk) internal_reset <= 1'b1;
        settle(2);
        chk({reset_pin_oe_n, reset_pin_low_n}, 8'h00);
        @(posedge clk) internal_reset <= 1'b0;
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
